/* hw/led_sink_serial_command_port.sv */
// Serial command port of a sixteen-channel sink driver, with its FIFO.
// Assumes link pins are asynchronous; fault inputs are on clk.
`timescale 1ns/1ps
`include "led_sink_map.svh"

// ****************************************
// Event FIFO
// ****************************************
module led_sink_fifo #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               rd;
      logic [AW-1:0]               wr;
      logic [CW-1:0]               cnt;
   } fifo_s;
   fifo_s st;
   fifo_s next_st;
   logic  push;
   logic  pop;

   assign in_ready  = (st.cnt != CW'(DEPTH));
   assign out_valid = (st.cnt != '0);
   assign out_data  = st.mem[st.rd];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb
   begin
      next_st = st;
      if (push)
      begin
         next_st.mem[st.wr] = in_data;
         next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
      end
      if (pop)
         next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
      next_st.cnt = st.cnt + CW'(push) - CW'(pop);
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         st <= '0;
      else
         st <= next_st;
   end
endmodule // led_sink_fifo

// Functional notes
// - Each serial bit shifts into a sixteen-bit register on link clock rise.
// - Strobe with no clock edges, outside detection, copies shift register into output latch.
// - Channel sinks only while gate low and its latch bit is one.
// - Count clock rises inside strobe; act after strobe falls.
// - Strobe with no edges also ends any running detection.
// - Four edges load the configuration register from shift register.
// - Five edges put configuration into the shift path for readout.
// - Six edges start open detection; all channels forced off meanwhile.
// - Seven, eight, nine edges start short, status and leakage detection.
// - Thirteen edges wake the device from zero-power mode.
// - Fourteen or more edges do nothing.
// - Bit F selects edge rate, zero fast, default zero.
// - Bits D..C select short threshold, default 11.
// - Bits B..A select leakage threshold, default 11.
// - Bits 9..8 select detection current, default 00.
// - Bit 6 enables thermal shutdown, default one; shutdown turns all off.
// - Bits 5..0 set current gain, default 101011.
// - Stop strobe loads detection report into shift path for readout.
// - Flag zero means fault; all ones while in zero-power mode, except in status detection.
// - Detection ends with a strobe of any edge count while clock runs.
module led_sink_serial_command_port (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   resetn,
   // Link pins
   input  wire logic                   link_clk,
   input  wire logic                   serial_in,
   input  wire logic                   frame_strobe,
   input  wire logic                   output_gate_n,
   output logic                        serial_out,
   // Analog front end
   input  wire logic [15:0]            open_fault,
   input  wire logic [15:0]            short_fault,
   input  wire logic [15:0]            leak_fault,
   input  wire logic                   rext_open,
   input  wire logic                   temp_alarm,
   input  wire logic                   temp_shutdown,
   // Channel and analog controls
   output logic [15:0]                 sink_channels,
   output led_sink_pkg::cfg_s          driver_configuration,
   output led_sink_pkg::detect_e       detect_mode,
   output logic                        zero_power,
   output logic                        thermal_off
);
   import led_sink_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] prev;
      link_ev_s   pend;
      logic       pend_valid;
      logic [15:0] shift;
      logic [15:0] latch;
      cfg_s       cfg;
      detect_e    detect;
      logic [3:0] count;
      logic       framing;
      logic       exec_pend;
      logic       zero_power;
      logic       thermal_off;
      logic       serial_out;
      logic [15:0] sink;
   } core_s;
   core_s      st;
   core_s      next_st;
   link_ev_s   ev;
   link_ev_s   fifo_out;
   logic       fifo_in_ready;
   logic       fifo_out_valid;
   logic       fifo_pop;

   // Flag word loaded into the shift path at a stop strobe
   function automatic logic [15:0] report_word(
      input detect_e     mode,
      input logic [15:0] op,
      input logic [15:0] sh,
      input logic [15:0] lk,
      input logic [3:0]  stat,
      input logic        zp
   );
      logic [15:0] r;
      r = 16'hFFFF;
      if (mode == DET_OPEN)
         r = ~op;
      else if (mode == DET_SHORT)
         r = ~sh;
      else if (mode == DET_LEAK)
         r = ~lk;
      else if (mode == DET_STATUS)
         r = {12'hFFF, stat};
      if (zp && (mode != DET_STATUS))
         r = 16'hFFFF;
      return r;
   endfunction

   // ****************************************
   // Link event capture
   // ****************************************
   // Bit order in sync regs: 3 clock, 2 data, 1 strobe, 0 gate
   assign ev.clk_rise    = st.s2[3] && !st.prev[3];
   assign ev.data        = st.s2[2];
   assign ev.strobe_rise = st.s2[1] && !st.prev[1];
   assign ev.strobe_fall = !st.s2[1] && st.prev[1];
   assign fifo_pop       = fifo_out_valid && !st.exec_pend;

   led_sink_fifo #(
      .WIDTH (4),
      .DEPTH (8)
   ) u_fifo (
      .clk       (clk),
      .resetn    (resetn),
      .in_valid  (st.pend_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (st.pend),
      .out_valid (fifo_out_valid),
      .out_ready (!st.exec_pend),
      .out_data  (fifo_out)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      next_st = st;
      next_st.s1 = {link_clk, serial_in, frame_strobe, output_gate_n};
      next_st.s2 = st.s1;
      next_st.prev = st.s2;
      // Held word waits while the FIFO is full
      if (st.pend_valid && fifo_in_ready)
         next_st.pend_valid = 1'b0;
      if (ev.clk_rise || ev.strobe_rise || ev.strobe_fall)
      begin
         next_st.pend = next_st.pend_valid ? (st.pend | ev) : ev;
         next_st.pend_valid = 1'b1;
      end
      if (fifo_pop)
      begin
         if (fifo_out.strobe_rise)
         begin
            next_st.count = `CMD_LATCH;
            next_st.framing = 1'b1;
         end
         if (fifo_out.clk_rise)
         begin
            next_st.serial_out = st.shift[15];
            next_st.shift = {st.shift[14:0], fifo_out.data};
            if (next_st.framing && (next_st.count != `CNT_SAT))
               next_st.count = next_st.count + 4'h1;
         end
         if (fifo_out.strobe_fall)
         begin
            next_st.framing = 1'b0;
            next_st.exec_pend = 1'b1;
         end
      end
      if (st.exec_pend)
      begin
         next_st.exec_pend = 1'b0;
         // Any strobe ends detection; only zero edges yields a report
         next_st.detect = DET_IDLE;
         unique case (st.count)
            `CMD_LATCH:
            begin
               if (st.detect != DET_IDLE)
                  next_st.shift = report_word(st.detect, open_fault, short_fault,
                     leak_fault, {st.zero_power, !st.thermal_off, !temp_alarm,
                     !rext_open}, st.zero_power);
               else
               begin
                  next_st.latch = st.shift;
                  if (st.cfg.zero_power_en && (st.shift == 16'h0000))
                     next_st.zero_power = 1'b1;
               end
            end
            `CMD_WR_CFG: next_st.cfg = cfg_s'(st.shift & `CFG_WMASK);
            `CMD_RD_CFG: next_st.shift = st.cfg;
            `CMD_OPEN:   next_st.detect = DET_OPEN;
            `CMD_SHORT:  next_st.detect = DET_SHORT;
            `CMD_STATUS: next_st.detect = DET_STATUS;
            `CMD_LEAK:   next_st.detect = DET_LEAK;
            `CMD_WAKE:
            begin
               next_st.zero_power = 1'b0;
               next_st.thermal_off = 1'b0;
            end
            default: next_st.detect = DET_IDLE;
         endcase
      end
      if (!st.cfg.zero_power_en)
         next_st.zero_power = 1'b0;
      // Hardware set wins over a wake clear
      if (st.cfg.thermal_en && temp_shutdown)
         next_st.thermal_off = 1'b1;
      if ((st.detect != DET_IDLE) || st.thermal_off || st.zero_power)
         next_st.sink = 16'h0000;
      else
         next_st.sink = st.s2[0] ? 16'h0000 : st.latch;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st <= '0;
         // Idle pin levels: clock low, strobe low, gate high
         st.s1 <= 4'h1;
         st.s2 <= 4'h1;
         st.prev <= 4'h1;
         st.cfg <= cfg_s'(`CFG_RESET);
         st.detect <= DET_IDLE;
      end
      else
         st <= next_st;
   end

   assign serial_out           = st.serial_out;
   assign sink_channels        = st.sink;
   assign driver_configuration = st.cfg;
   assign detect_mode          = st.detect;
   assign zero_power           = st.zero_power;
   assign thermal_off          = st.thermal_off;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_exec(logic [3:0] c);
      st.exec_pend && (st.count == c);
   endsequence

   a_strobe_latch: assert property (s_exec(`CMD_LATCH) ##0 (st.detect == DET_IDLE)
      |=> st.latch == $past(st.shift)) else $error("latch not loaded");
   a_gate_sink: assert property ((|sink_channels) |-> $past(!st.s2[0])
      && ((sink_channels & ~$past(st.latch)) == 16'h0000))
      else $error("sink without gate or latch");
   a_count_cap: assert property (st.count <= `CNT_SAT)
      else $error("edge count past cap");
   a_stop_report: assert property (s_exec(`CMD_LATCH) ##0 (st.detect == DET_OPEN)
      ##0 !st.zero_power |=> (st.detect == DET_IDLE) && (st.shift == ~$past(open_fault)))
      else $error("stop did not load report");
   a_cfg_write: assert property (s_exec(`CMD_WR_CFG)
      |=> st.cfg == ($past(st.shift) & `CFG_WMASK)) else $error("cfg write");
   a_cfg_read: assert property (s_exec(`CMD_RD_CFG) |=> st.shift == $past(st.cfg))
      else $error("cfg read");
   a_detect_off: assert property ((st.detect != DET_IDLE) |=> sink_channels == 16'h0000)
      else $error("channel on in detection");
   a_short_start: assert property (s_exec(`CMD_SHORT) |=> st.detect == DET_SHORT)
      else $error("short detection not started");
   a_wake_clear: assert property (s_exec(`CMD_WAKE) ##0 !temp_shutdown
      |=> !st.zero_power && !st.thermal_off) else $error("wake failed");
   a_no_action: assert property (st.exec_pend && (st.count >= 4'hA)
      && (st.count != `CMD_WAKE) |=> $stable(st.cfg) && $stable(st.latch))
      else $error("idle count acted");
   a_chain_out: assert property (fifo_pop && fifo_out.clk_rise
      |=> serial_out == $past(st.shift[15])) else $error("chain bit lost");
   a_therm_dark: assert property (st.thermal_off |=> sink_channels == 16'h0000)
      else $error("channel on in thermal shutdown");
endmodule // led_sink_serial_command_port

/* common/led_sink_map.svh */
// Offsets, reset values and command counts of the sink driver.
// Assumes inclusion by bare name from the package and design.
`ifndef LED_SINK_MAP_SVH
`define LED_SINK_MAP_SVH
// ****************************************
// Configuration word
// ****************************************
`define CFG_RESET      16'h3C6B
`define CFG_WMASK      16'hBFFF
`define CFG_POS_SLOW   15
`define CFG_POS_ZP     7
`define CFG_POS_THERM  6
// ****************************************
// Edge counts per command
// ****************************************
`define CMD_LATCH      4'h0
`define CMD_WR_CFG     4'h4
`define CMD_RD_CFG     4'h5
`define CMD_OPEN       4'h6
`define CMD_SHORT      4'h7
`define CMD_STATUS     4'h8
`define CMD_LEAK       4'h9
`define CMD_WAKE       4'hD
`define CNT_SAT        4'hE
`endif

/* common/led_sink_pkg.sv */
// Types shared by the sink driver serial port.
// Assumes led_sink_map.svh on the include path.
package led_sink_pkg;
`include "led_sink_map.svh"
   typedef struct packed {
      logic       slow_edges;
      logic       rsvd;
      logic [1:0] short_thresh;
      logic [1:0] leak_thresh;
      logic [1:0] detect_current;
      logic       zero_power_en;
      logic       thermal_en;
      logic [5:0] gain;
   } cfg_s;
   typedef struct packed {
      logic clk_rise;
      logic data;
      logic strobe_rise;
      logic strobe_fall;
   } link_ev_s;
   typedef enum logic [4:0] {
      DET_IDLE   = 5'b00001,
      DET_OPEN   = 5'b00010,
      DET_SHORT  = 5'b00100,
      DET_STATUS = 5'b01000,
      DET_LEAK   = 5'b10000
   } detect_e;
endpackage

/* verif/led_ctrl_model.sv */
// Controller model driving the link pins of one sink driver.
// Assumes clk is the bench clock; pins change just after its rise.
`timescale 1ns/1ps
// ****
// Controller
// ****
module led_ctrl_model (
   // Clock
   input  wire logic clk,
   // Link pins
   output logic      link_clk,
   output logic      serial_in,
   output logic      frame_strobe,
   output logic      output_gate_n,
   input  wire logic serial_out
);
   initial
   begin
      link_clk      = 1'b0;
      serial_in     = 1'b0;
      frame_strobe  = 1'b0;
      output_gate_n = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic gate(input logic v);
      output_gate_n <= v;
      tick(8);
   endtask
   // Detection left running well past its operation time
   task automatic dwell();
      tick(90);
   endtask
   // One bit, then the displaced bit is sampled
   task automatic pulse(input logic b, input logic s, output logic q);
      serial_in    <= b;
      frame_strobe <= s;
      tick(3);
      link_clk <= 1'b1;
      tick(3);
      link_clk  <= 1'b0;
      serial_in <= ~b;
      tick(4);
      q = serial_out;
   endtask
   // Sixteen bits, last n framed; n below zero only shifts
   task automatic send(input logic [15:0] w, input int n, output logic [15:0] r);
      for (int i = 15; i >= 0; i--)
         pulse(w[i], i < n, r[i]);
      if (n == 0)
      begin
         frame_strobe <= 1'b1;
         tick(3);
      end
      frame_strobe <= 1'b0;
      tick(12);
   endtask
endmodule // led_ctrl_model

/* verif/tb_top.sv */
// Self-checking bench for the sink driver serial command port.
// Assumes led_ctrl_model drives the link pins; faults come from here.
`timescale 1ns/1ps
`include "led_sink_map.svh"
// ****
// Bench
// ****
module tb_top;
   import led_sink_pkg::*;
   typedef struct packed {
      logic [15:0] sink;
      logic [15:0] cfg;
      detect_e     mode;
      logic        zp;
   } note_s;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [15:0] open_fault = 16'h0000;
   logic [15:0] short_fault = 16'h0000;
   logic [15:0] leak_fault = 16'h0000;
   logic        rext_open = 1'b0;
   logic        temp_alarm = 1'b0;
   logic        temp_shutdown = 1'b0;
   logic        link_clk;
   logic        serial_in;
   logic        frame_strobe;
   logic        output_gate_n;
   logic        serial_out;
   logic [15:0] sink_channels;
   cfg_s        driver_configuration;
   detect_e     detect_mode;
   logic        zero_power;
   logic        thermal_off;
   note_s       notes[$];
   logic [15:0] exp_cfg;
   logic [15:0] exp_lat = 16'h0000;
   logic        gn = 1'b1;
   int          n_fail = 0;
   int          samples_checked = 0;
   event        look;
   always #4 clk = ~clk;
   led_ctrl_model u_led_ctrl_model (
      .clk(clk), .link_clk(link_clk), .serial_in(serial_in),
      .frame_strobe(frame_strobe), .output_gate_n(output_gate_n),
      .serial_out(serial_out)
   );
   led_sink_serial_command_port u_led_sink_serial_command_port (
      .clk(clk), .resetn(resetn), .link_clk(link_clk), .serial_in(serial_in),
      .frame_strobe(frame_strobe), .output_gate_n(output_gate_n),
      .serial_out(serial_out), .open_fault(open_fault), .short_fault(short_fault),
      .leak_fault(leak_fault), .rext_open(rext_open), .temp_alarm(temp_alarm),
      .temp_shutdown(temp_shutdown), .sink_channels(sink_channels),
      .driver_configuration(driver_configuration), .detect_mode(detect_mode),
      .zero_power(zero_power), .thermal_off(thermal_off)
   );
   task automatic check(input logic [37:0] seen, input logic [37:0] want);
      samples_checked++;
      if (seen !== want)
      begin
         n_fail++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic cmp16(input logic [15:0] seen, input logic [15:0] want);
      check({22'h000000, seen}, {22'h000000, want});
   endtask
   // Channels read dark while detecting or gated off
   task automatic expect_now(input detect_e m, input logic z);
      notes.push_back({(m != DET_IDLE || gn) ? 16'h0000 : exp_lat, exp_cfg, m, z});
      ->look;
   endtask
   always @(look)
      check({sink_channels, driver_configuration, detect_mode, zero_power}, notes.pop_front());
   task automatic send(input logic [15:0] w, input int n, output logic [15:0] r);
      u_led_ctrl_model.send(w, n, r);
   endtask
   function automatic logic [15:0] report(input int k);
      case (k)
         0: return ~open_fault;
         1: return ~short_fault;
         2: return {12'hFFF, 1'b0, 1'b1, ~temp_alarm, ~rext_open};
         default: return ~leak_fault;
      endcase
   endfunction
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (60000) @(posedge clk);
      n_fail++;
      wrap_up();
   end
   initial
   begin
      logic [15:0] w;
      logic [15:0] r;
      logic [3:0]  idle_cnt [8];
      detect_e     det_tab [4];
      idle_cnt = '{4'h1, 4'h2, 4'h3, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF};
      det_tab  = '{DET_OPEN, DET_SHORT, DET_STATUS, DET_LEAK};
      void'($urandom(32'hE255));
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      repeat (6) @(posedge clk);
      exp_cfg = `CFG_RESET;
      expect_now(DET_IDLE, 1'b0);
      $display("test reset done");
      for (int k = 0; k < 3; k++)
      begin
         w = 16'($urandom) & 16'hFF7F;
         send(w, 4, r);
         exp_cfg = w & `CFG_WMASK;
         expect_now(DET_IDLE, 1'b0);
         send(16'($urandom), 5, r);
         send(w, -1, r);
         cmp16(r, exp_cfg);
         send(16'h0000, -1, r);
         cmp16(r, w);
      end
      $display("test configuration done");
      gn = 1'b0;
      u_led_ctrl_model.gate(1'b0);
      for (int k = 0; k < 4; k++)
      begin
         w = 16'($urandom) | 16'h0001;
         send(w, 0, r);
         exp_lat = w;
         expect_now(DET_IDLE, 1'b0);
      end
      gn = 1'b1;
      u_led_ctrl_model.gate(1'b1);
      expect_now(DET_IDLE, 1'b0);
      gn = 1'b0;
      u_led_ctrl_model.gate(1'b0);
      foreach (idle_cnt[k])
      begin
         send(16'($urandom), int'(idle_cnt[k]), r);
         expect_now(DET_IDLE, 1'b0);
      end
      $display("test latch and idle counts done");
      open_fault  <= 16'($urandom);
      short_fault <= 16'($urandom);
      leak_fault  <= 16'($urandom);
      rext_open   <= 1'($urandom);
      temp_alarm  <= 1'($urandom);
      repeat (2) @(posedge clk);
      for (int k = 0; k < 4; k++)
      begin
         send(16'($urandom), 6 + k, r);
         expect_now(det_tab[k], 1'b0);
         u_led_ctrl_model.dwell();
         send(16'($urandom), 0, r);
         expect_now(DET_IDLE, 1'b0);
         send(16'h0000, -1, r);
         cmp16(r, report(k));
      end
      $display("test detection done");
      w = exp_cfg | 16'h00C0;
      send(w, 4, r);
      exp_cfg = w;
      send(16'h0000, 0, r);
      exp_lat = 16'h0000;
      expect_now(DET_IDLE, 1'b1);
      send(16'($urandom), 6, r);
      u_led_ctrl_model.dwell();
      send(16'($urandom), 0, r);
      send(16'h0000, -1, r);
      cmp16(r, 16'hFFFF);
      send(16'($urandom), 13, r);
      expect_now(DET_IDLE, 1'b0);
      $display("test zero power done");
      w = 16'($urandom) | 16'h0001;
      send(w, 0, r);
      exp_lat = w;
      expect_now(DET_IDLE, 1'b0);
      temp_shutdown <= 1'b1;
      repeat (2) @(posedge clk);
      temp_shutdown <= 1'b0;
      repeat (4) @(posedge clk);
      cmp16({thermal_off, 15'h0000}, 16'h8000);
      cmp16(sink_channels, 16'h0000);
      send(16'($urandom), 13, r);
      cmp16({thermal_off, 15'h0000}, 16'h0000);
      expect_now(DET_IDLE, 1'b0);
      $display("test thermal done");
      wrap_up();
   end
endmodule // tb_top
